// *** psb_pipelined_burst_sram.v ***
// pipelined burst sram core: decode, burst, array, output stage
`timescale 1ns/1ps
`include "psb_consts.vh"
module psb_pipelined_burst_sram #(
  parameter ADDR_W = `PSB_ADDR_W,
  parameter DEPTH = `PSB_DEPTH,
  parameter LANES = `PSB_LANES,
  parameter LANE_W = `PSB_LANE_W
) (
  input wire ref_clk_i,
  input wire srst_i,
  input wire [ADDR_W-3:0] addr_in_i,
  input wire [1:0] burst_addr_lsbs_i,
  input wire [LANES*LANE_W-1:0] byte_lane_data_i,
  output wire [LANES*LANE_W-1:0] byte_lane_data_o,
  output wire [LANES-1:0] byte_lane_data_oe_o,
  input wire controller_addr_strobe_n_i,
  input wire processor_addr_strobe_n_i,
  input wire burst_advance_n_i,
  input wire chip_sel_primary_n_i,
  input wire chip_sel_depth_hi_i,
  input wire chip_sel_depth_lo_n_i,
  input wire global_write_n_i,
  input wire write_gate_n_i,
  input wire [LANES-1:0] byte_write_n_i,
  input wire output_drive_en_n_i,
  input wire sleep_request_i,
  input wire burst_order_select_i,
  output wire [1:0] cycle_state_o,
  output wire low_power_o,
  output wire [ADDR_W-1:0] burst_addr_o
);

  // ----------------------------------------------------------------
  // state and pipeline registers
  // ----------------------------------------------------------------
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [ADDR_W-3:0] upper_q;
  reg [ADDR_W-3:0] upper_d;
  reg [ADDR_W-1:0] rd_addr_q;
  reg [ADDR_W-1:0] rd_addr_d;
  reg rd_pend_q;
  reg rd_pend_d;
  reg drive_q;
  reg drive_d;
  reg [LANES*LANE_W-1:0] dout_q;
  reg [ADDR_W-1:0] burst_addr_q;
  reg [ADDR_W-1:0] burst_addr_d;

  // ----------------------------------------------------------------
  // decode wires
  // ----------------------------------------------------------------
  reg depth_ok;
  reg proc_take;
  reg ctrl_take;
  reg strobe;
  reg deselect;
  reg begin_rd;
  reg begin_wr;
  reg running;
  reg cont;
  reg cont_wr;
  reg cont_rd;
  reg step;
  reg wr_go;
  reg [ADDR_W-1:0] ext_addr;
  reg [ADDR_W-1:0] cont_addr;
  reg [ADDR_W-1:0] wr_addr;
  wire is_write;
  wire [LANES-1:0] lane_en;
  wire [1:0] cur_lsbs;
  wire [1:0] nxt_lsbs;
  wire [LANES*LANE_W-1:0] rd_word;
  wire pins_on;

  // ----------------------------------------------------------------
  // write control decode
  // ----------------------------------------------------------------
  psb_write_decode u_wdec (
    .global_write_n_i(global_write_n_i),
    .write_gate_n_i(write_gate_n_i),
    .byte_write_n_i(byte_write_n_i),
    .is_write_o(is_write),
    .lane_en_o(lane_en)
  );

  // ----------------------------------------------------------------
  // burst counter
  // ----------------------------------------------------------------
  psb_burst_ctr u_ctr (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .load_i(begin_rd | begin_wr),
    .start_i(burst_addr_lsbs_i),
    .advance_i(step),
    .order_i(burst_order_select_i),
    .cur_o(cur_lsbs),
    .nxt_o(nxt_lsbs)
  );

  // ----------------------------------------------------------------
  // cycle decode
  // ----------------------------------------------------------------
  always @* begin
    depth_ok = chip_sel_depth_hi_i & ~chip_sel_depth_lo_n_i;
    // processor strobe only counts with primary select low
    proc_take = ~processor_addr_strobe_n_i & ~chip_sel_primary_n_i; // RULE14
    ctrl_take = ~controller_addr_strobe_n_i & ~proc_take;
    strobe = (proc_take | ctrl_take) & ~sleep_request_i;
    deselect = strobe & ~(~chip_sel_primary_n_i & depth_ok); // RULE15
    begin_rd = strobe & ~deselect & (proc_take | ~is_write); // RULE13
    begin_wr = strobe & ~deselect & ~proc_take & is_write; // RULE12
    running = (state_q == `PSB_ST_READ) |
              (state_q == `PSB_ST_WRITE);
    cont = ~strobe & running & ~sleep_request_i;
    cont_wr = cont & is_write;
    cont_rd = cont & ~is_write;
    step = cont & ~burst_advance_n_i; // RULE16
    ext_addr = {addr_in_i, burst_addr_lsbs_i};
    if (step) begin
      cont_addr = {upper_q, nxt_lsbs}; // RULE23
    end else begin
      cont_addr = {upper_q, cur_lsbs}; // RULE16
    end
    wr_go = begin_wr | cont_wr; // RULE4
    if (begin_wr) begin
      wr_addr = ext_addr;
    end else begin
      wr_addr = cont_addr;
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always @* begin
    state_d = state_q;
    upper_d = upper_q;
    rd_addr_d = rd_addr_q;
    rd_pend_d = 1'b0;
    drive_d = rd_pend_q; // RULE3
    burst_addr_d = burst_addr_q;
    if (sleep_request_i) begin
      // internal clock stopped, pins released
      state_d = `PSB_ST_SLEEP; // RULE20
      drive_d = 1'b0;
    end else if (deselect) begin
      if (state_q != `PSB_ST_SLEEP) begin
        state_d = `PSB_ST_DESEL;
      end
      drive_d = 1'b0; // RULE22
    end else if (begin_rd) begin
      state_d = `PSB_ST_READ; // RULE21
      upper_d = addr_in_i;
      rd_addr_d = ext_addr;
      rd_pend_d = 1'b1;
      burst_addr_d = ext_addr;
    end else if (begin_wr) begin
      state_d = `PSB_ST_WRITE; // RULE21
      upper_d = addr_in_i;
      drive_d = 1'b0;
      burst_addr_d = ext_addr;
    end else if (cont_rd) begin
      state_d = `PSB_ST_READ;
      rd_addr_d = cont_addr;
      rd_pend_d = 1'b1;
      burst_addr_d = cont_addr;
    end else if (cont_wr) begin
      state_d = `PSB_ST_WRITE;
      drive_d = 1'b0;
      burst_addr_d = cont_addr;
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      state_q <= `PSB_ST_DESEL;
      upper_q <= {(ADDR_W-2){1'b0}};
      rd_addr_q <= {ADDR_W{1'b0}};
      rd_pend_q <= 1'b0;
      drive_q <= 1'b0;
      burst_addr_q <= {ADDR_W{1'b0}};
    end else begin
      state_q <= state_d; // RULE1
      upper_q <= upper_d;
      rd_addr_q <= rd_addr_d;
      rd_pend_q <= rd_pend_d;
      drive_q <= drive_d; // RULE17
      burst_addr_q <= burst_addr_d;
    end
  end

  // ----------------------------------------------------------------
  // storage array, one memory per byte lane
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : g_lane
      reg [LANE_W-1:0] mem [0:DEPTH-1]; // RULE2
      always @(posedge ref_clk_i) begin
        if (wr_go & lane_en[g]) begin
          mem[wr_addr] <= byte_lane_data_i[g*LANE_W +: LANE_W]; // RULE5
        end
      end
      assign rd_word[g*LANE_W +: LANE_W] = mem[rd_addr_q];
    end
  endgenerate

  // ----------------------------------------------------------------
  // output register
  // ----------------------------------------------------------------
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      dout_q <= {(LANES*LANE_W){1'b0}};
    end else if (rd_pend_q & ~sleep_request_i) begin
      dout_q <= rd_word; // RULE3
    end
  end

  // ----------------------------------------------------------------
  // pin drive, gated without the clock
  // ----------------------------------------------------------------
  assign pins_on = drive_q & ~output_drive_en_n_i & ~sleep_request_i; // RULE18
  assign byte_lane_data_oe_o = {LANES{pins_on}};
  assign byte_lane_data_o = dout_q;

  // ----------------------------------------------------------------
  // status
  // ----------------------------------------------------------------
  assign cycle_state_o = state_q;
  assign low_power_o = (state_q == `PSB_ST_SLEEP);
  assign burst_addr_o = burst_addr_q;

endmodule

// *** psb_consts.vh ***
// constants for the pipelined burst sram block
//
// Contract
// [RULE1] address, data and controls register on rising edge; enable, sleep, order do not.
// [RULE2] storage is 64K words of 32 bits in four byte lanes.
// [RULE3] read data passes an output register and appears one edge later.
// [RULE4] writes start at the clock edge and need no external pulse.
// [RULE5] with write gate low and global write high, exactly the lanes whose byte writes are low are written.
// [RULE6] global write low writes all four lanes regardless of other write controls.
// [RULE7] write when global write low or gate low with any byte write low.
// [RULE8] burst order input is held fixed; low linear, high interleaved.
// [RULE9] linear bursts add the beat count to the start, modulo four.
// [RULE10] interleaved bursts xor the start bits with the beat count.
// [RULE11] burst address inputs connect to the two lowest address bits.
// [RULE12] controller strobe with all selects latches address, starts read or write.
// [RULE13] processor strobe with all selects latches address, starts read only.
// [RULE14] primary select high ignores processor strobe, controller strobe deselects.
// [RULE15] strobe with depth selects inactive deselects, uses no address, pins high-z.
// [RULE16] without strobe, advance low steps the burst, high suspends on current address.
// [RULE17] a read from deselect keeps pins high-z while its address registers.
// [RULE18] output enable acts without clock; drive only reads while it is low.
// [RULE19] other party negates output enable before and through a write after a read.
// [RULE20] sleep high stops the clock, floats pins, keeps stored contents.
// [RULE21] after sleep ends, low power holds until a read or write starts.
// [RULE22] a registered deselect floats the outputs within one cycle.
// [RULE23] bursts wrap inside the four-word block; upper bits never change.
`ifndef PSB_CONSTS_VH
`define PSB_CONSTS_VH

`define PSB_ADDR_W 16
`define PSB_HI_W 14
`define PSB_DEPTH 65536
`define PSB_DATA_W 32
`define PSB_LANES 4
`define PSB_LANE_W 8

// cycle state codes
`define PSB_ST_DESEL 2'h0
`define PSB_ST_READ 2'h1
`define PSB_ST_WRITE 2'h2
`define PSB_ST_SLEEP 2'h3

// burst order select levels
`define PSB_ORDER_LINEAR 1'b0
`define PSB_ORDER_INTERLEAVED 1'b1

`endif

// *** psb_burst_ctr.v ***
// two-bit burst address counter, linear or interleaved
`timescale 1ns/1ps
`include "psb_consts.vh"
module psb_burst_ctr (
  input wire ref_clk_i,
  input wire srst_i,
  input wire load_i,
  input wire [1:0] start_i,
  input wire advance_i,
  input wire order_i,
  output reg [1:0] cur_o,
  output reg [1:0] nxt_o
);
  reg [1:0] start_q;
  reg [1:0] beat_q;
  reg [1:0] beat_nxt;

  always @* begin
    beat_nxt = beat_q + 2'h1;
    if (order_i == `PSB_ORDER_LINEAR) begin
      cur_o = start_q + beat_q; // RULE9
      nxt_o = start_q + beat_nxt; // RULE9
    end else begin
      cur_o = start_q ^ beat_q; // RULE10
      nxt_o = start_q ^ beat_nxt; // RULE10
    end
  end

  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      start_q <= 2'h0;
      beat_q <= 2'h0;
    end else if (load_i) begin
      start_q <= start_i;
      beat_q <= 2'h0;
    end else if (advance_i) begin
      beat_q <= beat_nxt; // RULE23
    end
  end
endmodule

// *** psb_write_decode.v ***
// write qualification and byte lane enables
`timescale 1ns/1ps
`include "psb_consts.vh"
module psb_write_decode (
  input wire global_write_n_i,
  input wire write_gate_n_i,
  input wire [3:0] byte_write_n_i,
  output reg is_write_o,
  output reg [3:0] lane_en_o
);
  always @* begin
    if (!global_write_n_i) begin
      lane_en_o = 4'hf; // RULE6
    end else if (!write_gate_n_i) begin
      lane_en_o = ~byte_write_n_i; // RULE5
    end else begin
      lane_en_o = 4'h0;
    end
    is_write_o = |lane_en_o; // RULE7
  end
endmodule

// *** psb_host_model.sv ***
// host side model: bus resolution and output enable control
`timescale 1ns/1ps
module psb_host_model (
  input wire ref_clk_i,
  input wire wr_drive_i,
  input wire hold_off_i,
  input wire [31:0] wdata_i,
  input wire [31:0] ram_q_i,
  input wire [3:0] ram_oe_i,
  output logic [31:0] bus_o,
  output logic oe_n_o
);
  logic [31:0] last_q = 32'h0;
  assign oe_n_o = wr_drive_i | hold_off_i;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (ram_oe_i[i])
        bus_o[8*i+:8] = ram_q_i[8*i+:8];
      else if (wr_drive_i)
        bus_o[8*i+:8] = wdata_i[8*i+:8];
      else
        bus_o[8*i+:8] = ~last_q[8*i+:8]; // floating lane never looks stale
    end
  end
  always @(posedge ref_clk_i) last_q <= bus_o;
endmodule

// *** psb_sram_props.sv ***
// port checks for the burst sram
`timescale 1ns/1ps
module psb_sram_props #(parameter ADDR_W = 16, DEPTH = 65536, LANES = 4,
  LANE_W = 8) (
  input wire ref_clk_i,
  input wire srst_i,
  input wire [ADDR_W-3:0] addr_in_i,
  input wire [1:0] burst_addr_lsbs_i,
  input wire [LANES-1:0] byte_lane_data_oe_o,
  input wire controller_addr_strobe_n_i,
  input wire processor_addr_strobe_n_i,
  input wire burst_advance_n_i,
  input wire chip_sel_primary_n_i,
  input wire chip_sel_depth_hi_i,
  input wire chip_sel_depth_lo_n_i,
  input wire global_write_n_i,
  input wire write_gate_n_i,
  input wire [LANES-1:0] byte_write_n_i,
  input wire output_drive_en_n_i,
  input wire sleep_request_i,
  input wire burst_order_select_i,
  input wire [1:0] cycle_state_o,
  input wire [ADDR_W-1:0] burst_addr_o
);
  wire zz = sleep_request_i;
  wire sel = !chip_sel_primary_n_i && chip_sel_depth_hi_i &&
    !chip_sel_depth_lo_n_i;
  wire pa = !processor_addr_strobe_n_i && !chip_sel_primary_n_i;
  wire acc = pa || !controller_addr_strobe_n_i;
  wire wr = !global_write_n_i || (!write_gate_n_i && !(&byte_write_n_i));
  wire run = !zz && !acc && cycle_state_o != 2'h0 && cycle_state_o != 2'h3;
  wire [ADDR_W-1:0] ext = {addr_in_i, burst_addr_lsbs_i};
  wire [ADDR_W-1:0] lin = {burst_addr_o[ADDR_W-1:2], burst_addr_o[1:0] + 2'h1};
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  sequence s_rd_begin;
    !zz && sel && (pa || (acc && !wr));
  endsequence
  sequence s_rd_keep;
    run && !wr && !output_drive_en_n_i;
  endsequence
  chk_begin_read:
    assert property (s_rd_begin |=> cycle_state_o == 2'h1 &&
      burst_addr_o == $past(ext)) else $error("read begin missed");
  chk_begin_write:
    assert property (!zz && sel && !pa && acc && wr |=> cycle_state_o == 2'h2)
      else $error("write begin missed");
  chk_deselect:
    assert property (!zz && acc && !sel |=> byte_lane_data_oe_o == 4'h0)
      else $error("deselect left pins driven");
  chk_suspend_hold:
    assert property (run && burst_advance_n_i |=> $stable(burst_addr_o))
      else $error("suspend moved address");
  chk_linear_step:
    assert property (run && !burst_advance_n_i && !burst_order_select_i |=>
      burst_addr_o == $past(lin)) else $error("linear step wrong");
  chk_read_drive:
    assert property (s_rd_begin ##1 s_rd_keep ##1 (!output_drive_en_n_i &&
      !zz) |-> byte_lane_data_oe_o == 4'hf) else $error("read not driven");
  chk_first_float:
    assert property (cycle_state_o == 2'h0 ##0 s_rd_begin |=>
      byte_lane_data_oe_o == 4'h0) else $error("driven in address cycle");
  chk_oe_cause:
    assert property (byte_lane_data_oe_o != 4'h0 |-> !output_drive_en_n_i &&
      !zz && cycle_state_o == 2'h1) else $error("driven outside a read");
endmodule
bind psb_pipelined_burst_sram psb_sram_props #(.ADDR_W(ADDR_W),
  .DEPTH(DEPTH), .LANES(LANES), .LANE_W(LANE_W)) i_props (.*);

// *** psb_pipelined_burst_sram_tb.sv ***
// self-checking bench for the burst sram
`timescale 1ns/1ps
module psb_pipelined_burst_sram_tb;
  localparam logic [2:0] sel_on = 3'h2;
  localparam logic [5:0] no_wr = 6'h3f;
  localparam logic [15:0] addr_a = 16'h0104;
  localparam logic [13:0] base = 14'h08c;
  logic ref_clk_i = 1'h0, srst_i = 1'h1, sleep_request_i = 1'h0;
  logic burst_order_select_i = 1'h0, burst_advance_n_i = 1'h1;
  logic controller_addr_strobe_n_i = 1'h1, processor_addr_strobe_n_i = 1'h1;
  logic chip_sel_primary_n_i = 1'h1, chip_sel_depth_hi_i = 1'h0;
  logic chip_sel_depth_lo_n_i = 1'h1, global_write_n_i = 1'h1;
  logic write_gate_n_i = 1'h1, wdrv = 1'h0, hold = 1'h0;
  logic [13:0] addr_in_i = 14'h0;
  logic [1:0] burst_addr_lsbs_i = 2'h0;
  logic [3:0] byte_write_n_i = 4'hf;
  logic [31:0] wdata = 32'h0, exp;
  logic [2:0] dsel [3] = '{3'h6, 3'h0, 3'h3};
  wire [31:0] byte_lane_data_i, byte_lane_data_o;
  wire [3:0] byte_lane_data_oe_o;
  wire output_drive_en_n_i, low_power_o;
  wire [1:0] cycle_state_o;
  wire [15:0] burst_addr_o;
  int num_errors = 0, checks_done = 0;
  psb_pipelined_burst_sram i_dut (.*);
  psb_host_model i_host (.ref_clk_i(ref_clk_i), .wr_drive_i(wdrv),
    .hold_off_i(hold), .wdata_i(wdata), .ram_q_i(byte_lane_data_o),
    .ram_oe_i(byte_lane_data_oe_o), .bus_o(byte_lane_data_i),
    .oe_n_o(output_drive_en_n_i));
  initial forever #4 ref_clk_i = ~ref_clk_i;
  task automatic chk(input string what, input logic [31:0] seen, e);
    checks_done++;
    if (seen !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, e, seen);
    end
  endtask
  task automatic go(input logic [2:0] s, input logic c, p, a,
    input logic [15:0] ad, input logic [5:0] w, input logic [31:0] d);
    {chip_sel_primary_n_i, chip_sel_depth_hi_i, chip_sel_depth_lo_n_i} = s;
    {controller_addr_strobe_n_i, processor_addr_strobe_n_i} = {c, p};
    burst_advance_n_i = a;
    {addr_in_i, burst_addr_lsbs_i} = ad;
    {global_write_n_i, write_gate_n_i, byte_write_n_i} = w;
    wdata = d;
    wdrv = !c && p && (!w[5] || (!w[4] && w[3:0] != 4'hf));
  endtask
  task automatic wr(input logic [15:0] ad, input logic [5:0] w, input [31:0] d);
    @(negedge ref_clk_i) go(sel_on, 1'h0, 1'h1, 1'h1, ad, w, d);
  endtask
  task automatic rd(input logic [15:0] ad, input logic [31:0] e);
    @(negedge ref_clk_i) go(sel_on, 1'h0, 1'h1, 1'h1, ad, no_wr, 32'h0);
    @(negedge ref_clk_i) go(sel_on, 1'h1, 1'h1, 1'h1, ad, no_wr, 32'h0);
    @(negedge ref_clk_i);
    chk("read data", byte_lane_data_i, e);
    chk("read enable", byte_lane_data_oe_o, 32'hf);
  endtask
  task automatic burst(input logic o, input logic [1:0] s, input [2:0] ds);
    logic [1:0] q, p;
    burst_order_select_i = o;
    @(negedge ref_clk_i) go(sel_on, 1'h0, 1'h1, 1'h1, {base, s}, no_wr, 32'h0);
    for (int j = 0; j < 5; j++) begin
      @(negedge ref_clk_i);
      p = q;
      q = o ? s ^ j[1:0] : s + j[1:0];
      chk("burst addr", burst_addr_o, {base, q});
      if (j == 0)
        chk("address cycle", byte_lane_data_oe_o, 32'h0);
      else
        chk("burst data", byte_lane_data_i, {16'hc0de, base, p});
      go(j == 2 ? 3'h6 : sel_on, 1'h1, j != 2, 1'h0, 16'h0, no_wr, 32'h0);
    end
    @(negedge ref_clk_i) go(ds, 1'h0, 1'h1, 1'h1, 16'h0, no_wr, 32'h0);
    @(negedge ref_clk_i);
    chk("deselect", {cycle_state_o, byte_lane_data_oe_o}, 32'h0);
  endtask
  task automatic results();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    #200000;
    num_errors++;
    results();
  end
  initial begin
    repeat (8) @(posedge ref_clk_i);
    @(negedge ref_clk_i) srst_i = 1'h0;
    chk("reset", {cycle_state_o, low_power_o, byte_lane_data_oe_o}, 32'h0);
    wr(addr_a, 6'h0a, 32'h11223344);
    exp = 32'h11223344;
    rd(addr_a, exp);
    for (int i = 0; i < 4; i++) begin
      wr(addr_a, {2'h2, ~(4'h1 << i)}, 32'h5a5a5a5a);
      exp[8*i+:8] = 8'h5a;
      rd(addr_a, exp);
    end
    wr(addr_a, 6'h2f, 32'h0);
    @(negedge ref_clk_i);
    chk("gate only", cycle_state_o, 32'h1);
    wr(addr_a, 6'h20, 32'h01020304);
    exp = 32'h01020304;
    rd(addr_a, exp);
    @(negedge ref_clk_i) go(sel_on, 1'h1, 1'h0, 1'h1, addr_a, 6'h0, 32'h0);
    rd(addr_a, exp);
    for (int k = 0; k < 4; k++)
      wr({base, k[1:0]}, 6'h1f, {16'hc0de, base, k[1:0]});
    @(negedge ref_clk_i) go(3'h0, 1'h0, 1'h1, 1'h1, 16'h0, no_wr, 32'h0);
    for (int o = 0; o < 2; o++)
      for (int s = 0; s < 4; s++)
        burst(o[0], s[1:0], dsel[s % 3]);
    rd(addr_a, exp);
    #1 hold = 1'h1;
    #1 chk("enable off", byte_lane_data_oe_o, 32'h0);
    hold = 1'h0;
    #1 chk("enable on", byte_lane_data_oe_o, 32'hf);
    sleep_request_i = 1'h1;
    #1 chk("sleep float", byte_lane_data_oe_o, 32'h0);
    repeat (3) @(negedge ref_clk_i);
    chk("sleep", low_power_o, 32'h1);
    sleep_request_i = 1'h0;
    go(3'h0, 1'h0, 1'h1, 1'h1, 16'h0, no_wr, 32'h0);
    repeat (2) @(negedge ref_clk_i);
    chk("stay low", low_power_o, 32'h1);
    rd(addr_a, exp);
    chk("wake", low_power_o, 32'h0);
    results();
  end
endmodule
